// File: rtl/sssref_defs.vh
// Constants for the spindle sync reference block.
// Assumes a 50 MHz system clock; included by its bare name.
`ifndef SSSREF_DEFS_VH
`define SSSREF_DEFS_VH
// ******************************
// Clock and times
// ******************************
`define SSSREF_CLK_HZ 50000000
`define SSSREF_CLK_NS 20
// Reference period 0.0111 s expressed in ns, and its cycle count
`define SSSREF_REF_PERIOD_NS 11100000
`define SSSREF_REF_PERIOD_CYC (`SSSREF_REF_PERIOD_NS / `SSSREF_CLK_NS)
// Reference high time, an arbitrary short mark
`define SSSREF_REF_HIGH_NS 10000
`define SSSREF_REF_HIGH_CYC (`SSSREF_REF_HIGH_NS / `SSSREF_CLK_NS)
// Delayed index offset 85.2 us in ns
`define SSSREF_DLY_NS 85200
`define SSSREF_DLY_CYC (`SSSREF_DLY_NS / `SSSREF_CLK_NS)
// Phase tolerance 20 us in ns
`define SSSREF_TOL_NS 20000
`define SSSREF_TOL_CYC (`SSSREF_TOL_NS / `SSSREF_CLK_NS)
// Slave lock limit 10 s in ms
`define SSSREF_LOCK_MS 10000
`define SSSREF_LOCK_CYC (`SSSREF_LOCK_MS * 50000)
// Index pulse width in cycles
`define SSSREF_IDX_W 8'h32
// ******************************
// Registers
// ******************************
`define SSSREF_OFS_LOCK 8'h11
`define SSSREF_OFS_SKEW 8'h12
`define SSSREF_LOCK_RST 8'h00
`define SSSREF_SKEW_RST 8'h00
// Lock field: 00 auto, 01 slave, 10 master, 11 off
`define SSSREF_RPL_AUTO 2'h0
`define SSSREF_RPL_SLAVE 2'h1
`define SSSREF_RPL_MASTER 2'h2
`define SSSREF_RPL_OFF 2'h3
// Sense key codes
`define SSSREF_SK_NONE 4'h0
`define SSSREF_SK_RECOV 4'h1
`define SSSREF_SK_HWERR 4'h4
`define SSSREF_SK_UATTN 4'h6
`endif

// File: rtl/sssref_top.v
// Spindle synchronisation reference: arbitration, reference generation,
// phase lock timing, skew, delayed index and RPL status reporting.
// Assumes mode bytes arrive as a byte write port and the spindle servo
// consumes the lock event and phase target produced here.
`timescale 1ns/1ps
`default_nettype none
`include "sssref_defs.vh"
// Contract
// - After head load, absent pulse takes master
// - Role change by mode write anytime
// - All drives including master lock pulse
// - Power-up synchronized unless jumper installed
// - Non-synchronized mode ignores the reference line
// - Master pulses at 90.09 Hz, idle low
// - Lock on reference falling edge
// - Slave locks within ten seconds
// - Delayed index 85.2 us after reference
// - Period 0.0111 s, jitter under 10 us
// - Lock field is low bits byte 17
// - Sync failure raises unit attention RPL change
// - Auto arbitration suppresses failure report
// - Lost sync when idle gives unit attention
// - Lost sync in I/O gives check condition
// - Skew lag is byte 18 over 256
// - Every skew value used exactly unrounded; code truncates the fraction of a cycle
// - Skew phase within 20 us
module sssref_top #(
    parameter [31:0] PERIOD_CYC = `SSSREF_REF_PERIOD_CYC,
    parameter [31:0] LOCK_CYC = `SSSREF_LOCK_CYC,
    parameter [31:0] ARB_CYC = `SSSREF_REF_PERIOD_CYC * 2
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Drive state
    input wire heads_loaded,
    input wire nosync_jumper,
    input wire io_active,
    input wire io_done,
    input wire io_ok,
    // Mode parameter byte port
    input wire mode_wr,
    input wire [7:0] mode_addr,
    input wire [7:0] mode_wdata,
    output reg [7:0] mode_rdata,
    // Shared reference line
    input wire ref_in,
    output wire ref_out,
    output wire ref_oe,
    // Spindle servo
    output reg lock_event,
    output reg phase_target,
    input wire spindle_index,
    output reg delayed_index_pulse,
    // Status
    output reg is_master,
    output reg in_sync,
    output reg sense_valid,
    output reg [3:0] sense_key,
    output reg unit_attention,
    output reg check_condition,
    input wire sense_ack
);

// ******************************
// Reset release
// ******************************
reg rst_s1_reg;
reg rst_s2_reg;
wire rst_l = rst_s2_reg;
always @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end
    else
    begin
        rst_s1_reg <= 1'b1;
        rst_s2_reg <= rst_s1_reg;
    end
end

// ******************************
// Mode bytes
// ******************************
reg [7:0] lock_ctl_reg;
reg [7:0] skew_reg;
reg jumper_reg;
reg strap_done_reg;
wire [1:0] rpl = lock_ctl_reg[1:0];
wire sync_on = !jumper_reg && (rpl != `SSSREF_RPL_OFF);
always @(posedge sys_clk or negedge rst_l)
begin
    if (!rst_l)
    begin
        lock_ctl_reg <= `SSSREF_LOCK_RST;
        skew_reg <= `SSSREF_SKEW_RST;
        jumper_reg <= 1'b0;
        strap_done_reg <= 1'b0;
    end
    else
    begin
        // Strap caught once after release, not under reset
        if (!strap_done_reg)
        begin
            jumper_reg <= nosync_jumper;
            strap_done_reg <= 1'b1;
        end
        if (mode_wr && mode_addr == `SSSREF_OFS_LOCK)
            lock_ctl_reg <= mode_wdata;
        if (mode_wr && mode_addr == `SSSREF_OFS_SKEW)
            skew_reg <= mode_wdata;
    end
end

always @*
begin
    case (mode_addr)
        `SSSREF_OFS_LOCK: mode_rdata = lock_ctl_reg;
        `SSSREF_OFS_SKEW: mode_rdata = skew_reg;
        default: mode_rdata = 8'h00;
    endcase
end

// ******************************
// Arbitration
// ******************************
reg [31:0] arb_cnt_reg;
reg arb_won_reg;
reg arb_done_reg;
reg ref_d_reg;
wire ref_fall = ref_d_reg && !ref_in;
always @(posedge sys_clk or negedge rst_l)
begin
    if (!rst_l)
    begin
        arb_cnt_reg <= 32'h0;
        arb_won_reg <= 1'b0;
        arb_done_reg <= 1'b0;
        ref_d_reg <= 1'b0;
    end
    else
    begin
        ref_d_reg <= ref_in;
        if (!heads_loaded || rpl != `SSSREF_RPL_AUTO)
        begin
            arb_cnt_reg <= 32'h0;
            arb_done_reg <= 1'b0;
            arb_won_reg <= 1'b0;
        end
        else if (!arb_done_reg)
        begin
            // Listen for two periods before claiming the line
            if (ref_fall)
            begin
                arb_done_reg <= 1'b1;
                arb_won_reg <= 1'b0;
            end
            else if (arb_cnt_reg >= ARB_CYC - 32'h1)
            begin
                arb_done_reg <= 1'b1;
                arb_won_reg <= 1'b1;
            end
            else
                arb_cnt_reg <= arb_cnt_reg + 32'h1;
        end
    end
end

// Host-only mastering needs no logic here: all-slave drives just sense
wire master_now = sync_on && ((rpl == `SSSREF_RPL_MASTER) || arb_won_reg);

// ******************************
// Reference generator
// ******************************
reg [31:0] per_cnt_reg;
reg ref_drv_reg;
always @(posedge sys_clk or negedge rst_l)
begin
    if (!rst_l)
    begin
        per_cnt_reg <= 32'h0;
        ref_drv_reg <= 1'b0;
        is_master <= 1'b0;
    end
    else
    begin
        is_master <= master_now;
        if (!master_now)
        begin
            per_cnt_reg <= 32'h0;
            ref_drv_reg <= 1'b0;
        end
        else
        begin
            // Crystal count gives fixed period, so no cycle jitter
            if (per_cnt_reg >= PERIOD_CYC - 32'h1)
                per_cnt_reg <= 32'h0;
            else
                per_cnt_reg <= per_cnt_reg + 32'h1;
            ref_drv_reg <= (per_cnt_reg < `SSSREF_REF_HIGH_CYC);
        end
    end
end
assign ref_out = ref_drv_reg;
assign ref_oe = is_master;

// ******************************
// Phase lock and skew
// ******************************
reg [31:0] since_fall_reg;
reg [31:0] lock_wait_reg;
reg tracking_reg;
reg [7:0] idx_w_reg;
reg spin_d_reg;
// Skew in cycles, numerator times period over 256, fraction of a cycle truncated
function [31:0] skew_cyc;
    input [7:0] num;
    reg [39:0] prod;
    begin
        prod = {32'h0, num} * {8'h00, PERIOD_CYC};
        skew_cyc = prod[39:8];
    end
endfunction
wire [31:0] target_cyc = skew_cyc(skew_reg);
wire spin_rise = spindle_index && !spin_d_reg;
wire [31:0] err_cyc = (since_fall_reg > target_cyc) ? since_fall_reg - target_cyc : target_cyc - since_fall_reg;
wire phase_ok = err_cyc <= `SSSREF_TOL_CYC;
always @(posedge sys_clk or negedge rst_l)
begin
    if (!rst_l)
    begin
        since_fall_reg <= 32'h0;
        lock_event <= 1'b0;
        phase_target <= 1'b0;
        delayed_index_pulse <= 1'b0;
        idx_w_reg <= 8'h00;
        spin_d_reg <= 1'b0;
    end
    else
    begin
        spin_d_reg <= spindle_index;
        lock_event <= sync_on && ref_fall;
        if (sync_on && ref_fall)
            since_fall_reg <= 32'h0;
        else if (since_fall_reg != 32'hffffffff)
            since_fall_reg <= since_fall_reg + 32'h1;
        phase_target <= sync_on && (since_fall_reg == target_cyc);
        // Fixed offset from the fall, so a large skew cannot push it past the next fall
        if (sync_on && since_fall_reg == `SSSREF_DLY_CYC)
            idx_w_reg <= `SSSREF_IDX_W;
        else if (idx_w_reg != 8'h00)
            idx_w_reg <= idx_w_reg - 8'h01;
        delayed_index_pulse <= (idx_w_reg != 8'h00);
    end
end

// ******************************
// Sync status and sense
// ******************************
reg lost_pend_reg;
wire report_fail = (rpl != `SSSREF_RPL_AUTO);
always @(posedge sys_clk or negedge rst_l)
begin
    if (!rst_l)
    begin
        lock_wait_reg <= 32'h0;
        tracking_reg <= 1'b0;
        in_sync <= 1'b0;
        sense_valid <= 1'b0;
        sense_key <= `SSSREF_SK_NONE;
        unit_attention <= 1'b0;
        check_condition <= 1'b0;
        lost_pend_reg <= 1'b0;
    end
    else
    begin
        if (!sync_on || !heads_loaded)
        begin
            lock_wait_reg <= 32'h0;
            tracking_reg <= 1'b0;
            in_sync <= 1'b0;
        end
        else
        begin
            tracking_reg <= 1'b1;
            if (spin_rise)
                in_sync <= phase_ok;
            if (!in_sync && tracking_reg && lock_wait_reg < LOCK_CYC)
                lock_wait_reg <= lock_wait_reg + 32'h1;
        end
        if (sense_ack)
        begin
            sense_valid <= 1'b0;
            unit_attention <= 1'b0;
            check_condition <= 1'b0;
            sense_key <= `SSSREF_SK_NONE;
        end
        // Set beats ack in same cycle
        if (!in_sync && tracking_reg && lock_wait_reg == LOCK_CYC - 32'h1 && report_fail)
        begin
            sense_valid <= 1'b1;
            unit_attention <= 1'b1;
            sense_key <= `SSSREF_SK_UATTN;
        end
        if (in_sync && spin_rise && !phase_ok)
        begin
            if (!io_active)
            begin
                sense_valid <= 1'b1;
                unit_attention <= 1'b1;
                sense_key <= `SSSREF_SK_UATTN;
            end
            else
                lost_pend_reg <= 1'b1;
        end
        else if (lost_pend_reg && io_done)
        begin
            lost_pend_reg <= 1'b0;
            sense_valid <= 1'b1;
            check_condition <= 1'b1;
            sense_key <= io_ok ? `SSSREF_SK_RECOV : `SSSREF_SK_HWERR;
        end
    end
end

endmodule
`default_nettype wire

// File: tb/spindle_sync_reference_bench.sv
// Bench for the spindle sync reference top, small count parameters.
// Assumes the checker is bound and the far side model is present.
`timescale 1ns/1ps
`default_nettype none
module spindle_sync_reference_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic heads_loaded = 1'b0, nosync_jumper = 1'b0, io_active = 1'b0, io_done = 1'b0, io_ok = 1'b0;
    logic mode_wr = 1'b0, sense_ack = 1'b0, drive_en = 1'b0, slip = 1'b0;
    logic [7:0] mode_addr = 8'h0, mode_wdata = 8'h0;
    wire [7:0] mode_rdata;
    wire [3:0] sense_key;
    wire ref_out, ref_oe, lock_event, phase_target, delayed_index_pulse, is_master, in_sync;
    wire sense_valid, unit_attention, check_condition, line_val, line_oe, spindle_index;
    wire ref_in = ref_oe ? ref_out : ((line_oe === 1'b1) && line_val);
    integer fails = 0, samples_checked = 0, cyc = 0, nlock = 0, n0 = 0, i = 0;
    sssref_top #(.PERIOD_CYC(32'h1388), .LOCK_CYC(32'h4e20), .ARB_CYC(32'hfa0)) sssref_top_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .heads_loaded(heads_loaded), .nosync_jumper(nosync_jumper),
        .io_active(io_active), .io_done(io_done), .io_ok(io_ok), .mode_wr(mode_wr), .mode_addr(mode_addr),
        .mode_wdata(mode_wdata), .mode_rdata(mode_rdata), .ref_in(ref_in), .ref_out(ref_out), .ref_oe(ref_oe),
        .lock_event(lock_event), .phase_target(phase_target), .spindle_index(spindle_index),
        .delayed_index_pulse(delayed_index_pulse), .is_master(is_master), .in_sync(in_sync),
        .sense_valid(sense_valid), .sense_key(sense_key), .unit_attention(unit_attention),
        .check_condition(check_condition), .sense_ack(sense_ack));
    sssref_far #(.PERIOD_CYC(32'h1388)) sssref_far_inst (.sys_clk(sys_clk), .drive_en(drive_en), .slip(slip),
        .line_val(line_val), .line_oe(line_oe), .phase_target(phase_target), .spindle_index(spindle_index));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        nlock <= nlock + ((lock_event === 1'b1) ? 1 : 0);
        if (cyc == 90000)
        begin
            fails = fails + 1;
            summarize();
        end
    end
    task summarize;
    begin
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
            fails = fails + 1;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
    endtask
    task tick;
    begin
        @(posedge sys_clk);
        #1;
    end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge sys_clk);
        mode_wr <= 1'b1;
        mode_addr <= a;
        mode_wdata <= d;
        @(posedge sys_clk);
        mode_wr <= 1'b0;
    end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
    begin
        @(posedge sys_clk);
        mode_addr <= a;
        tick();
        chk(mode_rdata, exp);
    end
    endtask
    // Reset is asserted in the caller's edge slot, so call right after an edge
    task do_reset;
    begin
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    end
    endtask
    initial
    begin
        @(posedge sys_clk);
        do_reset();
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h00);
        heads_loaded <= 1'b1;
        for (i = 0; i < 9000 && is_master !== 1'b1; i++) tick();
        chk({6'h0, is_master, ref_oe}, 8'h03);
        for (i = 0; i < 5000 && nlock == 0; i++) tick();
        chk({7'h0, nlock != 0}, 8'h01);
        wr(8'h12, 8'h40);
        wr(8'h11, 8'h01);
        rd(8'h11, 8'h01);
        rd(8'h13, 8'h00);
        chk({6'h0, is_master, ref_oe}, 8'h00);
        drive_en <= 1'b1;
        for (i = 0; i < 20000 && in_sync !== 1'b1; i++) tick();
        chk({7'h0, in_sync}, 8'h01);
        slip <= 1'b1;
        for (i = 0; i < 24000 && unit_attention !== 1'b1; i++) tick();
        chk({4'h0, sense_key}, 8'h06);
        sense_ack <= 1'b1;
        slip <= 1'b0;
        tick();
        sense_ack <= 1'b0;
        for (i = 0; i < 20000 && in_sync !== 1'b1; i++) tick();
        chk({6'h0, unit_attention, in_sync}, 8'h01);
        io_active <= 1'b1;
        slip <= 1'b1;
        for (i = 0; i < 12000 && in_sync !== 1'b0; i++) tick();
        @(posedge sys_clk);
        io_done <= 1'b1;
        io_ok <= 1'b1;
        @(posedge sys_clk);
        io_done <= 1'b0;
        io_active <= 1'b0;
        tick();
        tick();
        chk({3'h0, check_condition, sense_key}, 8'h11);
        sense_ack <= 1'b1;
        tick();
        sense_ack <= 1'b0;
        // Spindle still slipped, so the lock wait runs out as a slave
        for (i = 0; i < 20000 && unit_attention !== 1'b1; i++) tick();
        chk({2'h0, unit_attention, check_condition, sense_key}, 8'h26);
        drive_en <= 1'b0;
        wr(8'h11, 8'h02);
        tick();
        chk({6'h0, is_master, ref_oe}, 8'h03);
        @(posedge sys_clk);
        nosync_jumper <= 1'b1;
        slip <= 1'b0;
        drive_en <= 1'b1;
        do_reset();
        n0 = nlock;
        repeat (6000) tick();
        chk({6'h0, nlock == n0, in_sync}, 8'h02);
        summarize();
    end
endmodule
`default_nettype wire

// File: tb/sssref_far.sv
// Far side model: host reference source and an ideal spindle.
// Assumes the bench resolves the shared line with a pull-down.
`timescale 1ns/1ps
`default_nettype none
module sssref_far #(
    parameter [31:0] PERIOD_CYC = 32'h7d0
) (
    // Clock and controls
    input wire sys_clk,
    input wire drive_en,
    input wire slip,
    // Line and spindle
    output logic line_val,
    output logic line_oe,
    input wire phase_target,
    output logic spindle_index
);
    logic [31:0] cnt = 32'h0;
    logic [31:0] dly = 32'h0;
    // Released line falls to the pull-down, never holds its last level
    always @(posedge sys_clk)
    begin
        cnt <= (cnt >= PERIOD_CYC - 32'h1) ? 32'h0 : cnt + 32'h1;
        line_oe <= drive_en;
        line_val <= drive_en && cnt < 32'h64;
        dly <= phase_target ? 32'h4b0 : ((dly != 32'h0) ? dly - 32'h1 : 32'h0);
        spindle_index <= slip ? (dly == 32'h1) : phase_target;
    end
endmodule
`default_nettype wire

// File: tb/sssref_props_properties.sv
// Port checker for the spindle sync reference top.
// Assumes bind onto sssref_top with its count parameters.
`timescale 1ns/1ps
`default_nettype none
module sssref_props #(
    parameter [31:0] PERIOD_CYC = 32'h7d0,
    parameter [31:0] LOCK_CYC = 32'h4e20,
    parameter [31:0] ARB_CYC = 32'hfa0
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Inputs
    input wire nosync_jumper,
    input wire io_done,
    input wire io_ok,
    input wire mode_wr,
    input wire [7:0] mode_addr,
    input wire [7:0] mode_wdata,
    input wire ref_in,
    // Outputs
    input wire [7:0] mode_rdata,
    input wire ref_out,
    input wire ref_oe,
    input wire lock_event,
    input wire delayed_index_pulse,
    input wire is_master,
    input wire [3:0] sense_key,
    input wire unit_attention,
    input wire check_condition
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] per_cnt;
    logic [31:0] fall_cnt;
    logic [31:0] dip_cnt;
    logic seen;
    // **************
    // Helper counters
    // **************
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_cnt <= 32'h0;
            fall_cnt <= 32'h100;
            dip_cnt <= 32'h0;
            seen <= 1'b0;
        end
        else
        begin
            per_cnt <= $rose(ref_out) ? 32'h1 : per_cnt + 32'h1;
            fall_cnt <= $fell(ref_in) ? 32'h0 : fall_cnt + 32'h1;
            dip_cnt <= delayed_index_pulse ? dip_cnt + 32'h1 : 32'h0;
            seen <= ref_oe && (seen || $rose(ref_out));
        end
    end
    sequence s_wr_skew;
        mode_wr && mode_addr == 8'h12 ##1 mode_addr == 8'h12;
    endsequence
    property p_skew_rw;
        s_wr_skew |-> mode_rdata == $past(mode_wdata);
    endproperty
    a_skew_rw: assert property (p_skew_rw) else $error("skew readback");
    property p_master_oe;
        !ref_oe |-> !ref_out;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("line driven by slave");
    property p_period;
        $rose(ref_out) && seen |-> per_cnt == PERIOD_CYC;
    endproperty
    a_period: assert property (p_period) else $error("reference period");
    property p_lock_fall;
        lock_event |-> fall_cnt <= 32'h4;
    endproperty
    a_lock_fall: assert property (p_lock_fall) else $error("lock without fall");
    property p_nosync;
        nosync_jumper && $past(nosync_jumper, 8) |-> !lock_event;
    endproperty
    a_nosync: assert property (p_nosync) else $error("lock while unsynced");
    property p_dip_width;
        $fell(delayed_index_pulse) |-> dip_cnt == 32'h32;
    endproperty
    a_dip_width: assert property (p_dip_width) else $error("index width");
    // Fall plus 85.2 us, 20 us either way, in cycles
    property p_dip_delay;
        $rose(delayed_index_pulse) |-> fall_cnt >= 32'hcbc && fall_cnt <= 32'h148c;
    endproperty
    a_dip_delay: assert property (p_dip_delay) else $error("index delay");
    property p_ua_key;
        $rose(unit_attention) |-> sense_key == 4'h6;
    endproperty
    a_ua_key: assert property (p_ua_key) else $error("attention key");
    property p_cc_key;
        $rose(check_condition) |-> $past(io_done) && sense_key == ($past(io_ok) ? 4'h1 : 4'h4);
    endproperty
    a_cc_key: assert property (p_cc_key) else $error("check key");
endmodule
bind sssref_top sssref_props #(.PERIOD_CYC(PERIOD_CYC), .LOCK_CYC(LOCK_CYC), .ARB_CYC(ARB_CYC)) sssref_props_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .nosync_jumper(nosync_jumper), .io_done(io_done), .io_ok(io_ok),
    .mode_wr(mode_wr), .mode_addr(mode_addr), .mode_wdata(mode_wdata), .ref_in(ref_in),
    .mode_rdata(mode_rdata), .ref_out(ref_out), .ref_oe(ref_oe), .lock_event(lock_event),
    .delayed_index_pulse(delayed_index_pulse), .is_master(is_master), .sense_key(sense_key),
    .unit_attention(unit_attention), .check_condition(check_condition));
`default_nettype wire
